/* design/rdp_downlink.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rdp_map.svh"

// How it works
// - zero-reference mode measures a reference interval first; bit windows derive from it.
// - zero is ref-7..ref+8, one ref+9..ref+24; fast ref-3..+4, ref+5..+12.
// - normal pairs: 00 -7..+8, 01 +9..+24, 10 +25..+40, 11 +41..+56.
// - fast pairs: 00 -3..+4, 01 +5..+12, 10 +13..+20, 11 +21..+28.
// - a valid write waits a short clock delay before programming starts.
// - programming takes about 5.6 ms; success gives block read of written block.
// - program only validated commands on unlocked blocks; lock bit written with data.
// - erase, check zeros, program, check ones, in that order.
// - after page 1 write a single gap reads page 1; reset command ends it.
// - an interval below the lowest window flags a command error; one past the top window ends the frame.
// - in password mode the received password must match block 7.
// - without password: 38-bit write, 6-bit direct access, 2-bit short commands only.
// - with password here: 72-bit write, 40-bit direct access, 36-bit wake-up.
// - command errors except wake-up with answer-on-request give regular read from block 1, of page 1 for opcode 11, else page 0.
// - with answer-on-request set, a faulty wake-up stops all modulation.
// - locked target skips programming and stays in block read of that block.
// - failed verify stops modulation until the next command.
// - write carries opcode, lock bit, 32 data bits, 3-bit address.
// - password commands carry two zero pad bits between opcode and password.
module rdp_downlink
  import rdp_pkg::*;
#(
  parameter int PROG_CYCLES = `RDP_PROG_TIME_NS / `RDP_CLK_PERIOD_NS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_field_clk,
  input wire logic i_gap,
  input wire logic i_one_of_four,
  input wire logic i_fast,
  input wire logic i_password_mode_bit,
  input wire logic i_answer_on_request,
  input wire logic [31:0] i_password,
  input wire logic [15:0] i_lock_map,
  input wire logic i_nvm_ok,
  output logic [1:0] o_mode,
  output logic o_page,
  output logic [2:0] o_block,
  output logic o_cmd_err,
  output logic o_nvm_erase,
  output logic o_nvm_erase_chk,
  output logic o_nvm_program,
  output logic o_nvm_write_chk,
  output logic [3:0] o_nvm_addr,
  output logic [31:0] o_nvm_data,
  output logic o_nvm_lock
);

  localparam logic [20:0] STEP_CYC = 21'(PROG_CYCLES / `RDP_PROG_STEPS);

  // slot boundaries relative to the reference; top flag marks end of frame
  function automatic logic [3:0] classify(input logic [7:0] cnt, input logic [7:0] refc,
                                          input logic fast, input logic pair);
    logic [8:0] sum;
    logic [8:0] diff;
    logic [8:0] idx;
    logic [8:0] nsym;
    logic above;
    sum = {1'b0, cnt} + (fast ? `RDP_FST_LO_OFS : `RDP_NRM_LO_OFS);
    diff = sum - {1'b0, refc};
    idx = fast ? (diff >> `RDP_FST_WIN_LOG2) : (diff >> `RDP_NRM_WIN_LOG2);
    nsym = pair ? `RDP_SYM_PAIR : `RDP_SYM_BIT;
    above = (sum >= {1'b0, refc});
    classify = {above && (idx >= nsym), above && (idx < nsym), idx[1:0]};
  endfunction : classify

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finding
  logic fclk_s1, fclk_s2, fclk_s3;
  logic gap_s1, gap_s2, gap_s3;
  logic fclk_rise;
  logic gap_end;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      {fclk_s1, fclk_s2, fclk_s3} <= 3'h0;
      {gap_s1, gap_s2, gap_s3} <= 3'h0;
    end
    else
    begin
      {fclk_s1, fclk_s2, fclk_s3} <= {i_field_clk, fclk_s1, fclk_s2};
      {gap_s1, gap_s2, gap_s3} <= {i_gap, gap_s1, gap_s2};
    end
  end

  assign fclk_rise = fclk_s2 && !fclk_s3;
  assign gap_end = !gap_s2 && gap_s3;

  ////////////////////////////////////////////////////////////////////////////
  // interval measurement and symbol decoding
  rdp_phase_t phase;
  logic [7:0] cnt;
  logic [7:0] ref_len;
  logic [3:0] cls;
  logic push_valid;
  logic [3:0] push_data;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [3:0] buf_out_data;
  logic drain;
  logic overflow;

  assign cls = classify(cnt, ref_len, i_fast, i_one_of_four);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      phase <= RDP_P_IDLE;
      cnt <= 8'h00;
      ref_len <= 8'h00;
      push_valid <= 1'b0;
      push_data <= 4'h0;
    end
    else
    begin
      push_valid <= 1'b0;
      if (gap_end)
      begin
        cnt <= 8'h00;
        case (phase)
          RDP_P_IDLE: phase <= RDP_P_REF;
          RDP_P_REF:
          begin
            ref_len <= cnt;
            phase <= RDP_P_DATA;
          end
          RDP_P_DATA:
          begin
            push_valid <= 1'b1;
            if (!cls[2])
              push_data <= {RDP_K_BAD, 2'h0};
            else if (i_one_of_four)
              push_data <= {RDP_K_PAIR, cls[1:0]};
            else
              push_data <= {RDP_K_BIT, 1'b0, cls[0]};
          end
          default: phase <= RDP_P_IDLE;
        endcase
      end
      else if (phase == RDP_P_REF && cnt == `RDP_REF_TMO)
      begin
        push_valid <= 1'b1;
        push_data <= {RDP_K_END, 2'h0};
        phase <= RDP_P_IDLE;
      end
      else if (phase == RDP_P_DATA && cls[3])
      begin
        push_valid <= 1'b1;
        push_data <= {RDP_K_END, 2'h0};
        phase <= RDP_P_IDLE;
      end
      else if (fclk_rise && phase != RDP_P_IDLE && cnt != `RDP_CNT_MAX)
        cnt <= cnt + 8'h01;
    end
  end

  assign overflow = push_valid && !buf_in_ready;

  rdp_pair_buf #(
    .WIDTH(4)
  ) u_buf (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_valid(push_valid),
    .o_ready(buf_in_ready),
    .i_data(push_data),
    .o_valid(buf_out_valid),
    .i_ready(drain),
    .o_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command evaluation
  rdp_state_t state;
  logic [71:0] sr;
  logic [6:0] nbits;
  logic err_seen;
  logic page1_hold;
  logic [20:0] tmr;
  logic [71:0] top;
  logic [1:0] opc;
  logic pwd_ok;
  logic ev_err, ev_wake_err, ev_write, ev_direct, ev_short, ev_wake;
  logic ev_lock;
  logic [31:0] ev_data;
  logic [2:0] ev_addr;

  assign drain = (state == RDP_S_COLLECT);
  assign top = sr << (`RDP_CMD_MAX - nbits);
  assign opc = top[71:70];
  assign pwd_ok = (top[69:68] == 2'h0) && (top[67:36] == i_password);

  always_comb
  begin
    ev_err = err_seen;
    ev_wake_err = 1'b0;
    ev_write = 1'b0;
    ev_direct = 1'b0;
    ev_short = 1'b0;
    ev_wake = 1'b0;
    ev_lock = 1'b0;
    ev_data = 32'h0000_0000;
    ev_addr = 3'h0;
    if (!i_password_mode_bit)
    begin
      case (nbits)
        `RDP_LEN_STD_WR:
        begin
          ev_write = opc[1];
          ev_lock = top[69];
          ev_data = top[68:37];
          ev_addr = top[36:34];
        end
        `RDP_LEN_DIRECT:
        begin
          ev_direct = opc[1];
          ev_addr = top[68:66];
        end
        `RDP_LEN_SHORT: ev_short = 1'b1;
        `RDP_LEN_SINGLE: ev_short = 1'b0;
        default: ev_err = 1'b1;
      endcase
    end
    else
    begin
      case (nbits)
        `RDP_LEN_PWD_WR:
        begin
          ev_write = opc[1] && pwd_ok;
          ev_lock = top[35];
          ev_data = top[34:3];
          ev_addr = top[2:0];
        end
        `RDP_LEN_PWD_DIR:
        begin
          ev_direct = opc[1] && pwd_ok;
          ev_addr = top[34:32];
        end
        `RDP_LEN_WAKE:
        begin
          ev_wake = pwd_ok && !err_seen;
          ev_wake_err = i_answer_on_request && !ev_wake;
        end
        `RDP_LEN_SHORT: ev_short = 1'b1;
        `RDP_LEN_SINGLE: ev_short = 1'b0;
        default: ev_err = 1'b1;
      endcase
    end
    if ((nbits == `RDP_LEN_PWD_WR || nbits == `RDP_LEN_PWD_DIR || nbits == `RDP_LEN_WAKE)
        && i_password_mode_bit && !pwd_ok && !ev_wake_err)
      ev_err = 1'b1;
    if ((nbits == `RDP_LEN_STD_WR || nbits == `RDP_LEN_DIRECT) && !i_password_mode_bit && !opc[1])
      ev_err = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= RDP_S_COLLECT;
      sr <= '0;
      nbits <= 7'h00;
      err_seen <= 1'b0;
      page1_hold <= 1'b0;
      tmr <= 21'h0;
      o_mode <= RDP_M_REGULAR;
      o_page <= 1'b0;
      o_block <= `RDP_FIRST_BLOCK;
      o_cmd_err <= 1'b0;
      o_nvm_erase <= 1'b0;
      o_nvm_erase_chk <= 1'b0;
      o_nvm_program <= 1'b0;
      o_nvm_write_chk <= 1'b0;
      o_nvm_addr <= 4'h0;
      o_nvm_data <= 32'h0000_0000;
      o_nvm_lock <= 1'b0;
    end
    else
    begin
      o_cmd_err <= 1'b0;
      if (overflow)
        err_seen <= 1'b1;
      if (tmr != 21'h0)
        tmr <= tmr - 21'h1;
      case (state)
        RDP_S_COLLECT:
        begin
          if (buf_out_valid)
          begin
            case (buf_out_data[3:2])
              RDP_K_BIT:
              begin
                sr <= {sr[70:0], buf_out_data[0]};
                nbits <= (nbits == `RDP_LEN_LIMIT) ? nbits : nbits + 7'h01;
              end
              RDP_K_PAIR:
              begin
                sr <= {sr[69:0], buf_out_data[1:0]};
                nbits <= (nbits >= 7'h7E) ? `RDP_LEN_LIMIT : nbits + 7'h02;
              end
              RDP_K_BAD: err_seen <= 1'b1;
              default: state <= RDP_S_EVAL;
            endcase
          end
        end
        RDP_S_EVAL:
        begin
          state <= RDP_S_COLLECT;
          sr <= '0;
          nbits <= 7'h00;
          err_seen <= overflow;
          if (ev_wake_err)
            o_mode <= RDP_M_SILENT;
          else if (ev_err)
          begin
            o_mode <= RDP_M_REGULAR;
            o_page <= opc[1] & opc[0];
            o_block <= `RDP_FIRST_BLOCK;
            o_cmd_err <= 1'b1;
          end
          else if (ev_write)
          begin
            o_nvm_addr <= {opc[0], ev_addr};
            o_nvm_data <= ev_data;
            o_nvm_lock <= ev_lock;
            o_page <= opc[0];
            o_block <= ev_addr;
            if (i_lock_map[{opc[0], ev_addr}])
              o_mode <= RDP_M_BLOCK;
            else
            begin
              o_mode <= RDP_M_PROG;
              page1_hold <= opc[0];
              tmr <= 21'(`RDP_PROG_DELAY_CYC);
              state <= RDP_S_DELAY;
            end
          end
          else if (ev_direct)
          begin
            o_mode <= RDP_M_BLOCK;
            o_page <= opc[0];
            o_block <= ev_addr;
          end
          else if (ev_short)
          begin
            o_mode <= RDP_M_REGULAR;
            o_page <= (opc == `RDP_OP_RESET) ? 1'b0 : opc[0];
            o_block <= `RDP_FIRST_BLOCK;
            if (opc == `RDP_OP_RESET)
              page1_hold <= 1'b0;
          end
          else if (ev_wake)
          begin
            o_mode <= RDP_M_REGULAR;
            o_block <= `RDP_FIRST_BLOCK;
          end
          else if (page1_hold)
          begin
            o_mode <= RDP_M_REGULAR;
            o_page <= 1'b1;
            o_block <= `RDP_FIRST_BLOCK;
          end
        end
        RDP_S_DELAY:
        begin
          if (tmr == 21'h0)
          begin
            state <= RDP_S_ERASE;
            o_nvm_erase <= 1'b1;
            tmr <= STEP_CYC;
          end
        end
        RDP_S_ERASE:
        begin
          if (tmr == 21'h0)
          begin
            state <= RDP_S_ERASE_CHK;
            o_nvm_erase <= 1'b0;
            o_nvm_erase_chk <= 1'b1;
            tmr <= STEP_CYC;
          end
        end
        RDP_S_ERASE_CHK:
        begin
          if (tmr == 21'h0)
          begin
            o_nvm_erase_chk <= 1'b0;
            if (i_nvm_ok)
            begin
              state <= RDP_S_PROGRAM;
              o_nvm_program <= 1'b1;
              tmr <= STEP_CYC;
            end
            else
            begin
              state <= RDP_S_COLLECT;
              o_mode <= RDP_M_SILENT;
            end
          end
        end
        RDP_S_PROGRAM:
        begin
          if (tmr == 21'h0)
          begin
            state <= RDP_S_WRITE_CHK;
            o_nvm_program <= 1'b0;
            o_nvm_write_chk <= 1'b1;
            tmr <= STEP_CYC;
          end
        end
        RDP_S_WRITE_CHK:
        begin
          if (tmr == 21'h0)
          begin
            state <= RDP_S_COLLECT;
            o_nvm_write_chk <= 1'b0;
            o_mode <= i_nvm_ok ? RDP_M_BLOCK : RDP_M_SILENT;
          end
        end
        default: state <= RDP_S_COLLECT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_ref_capture: assert property (gap_end && phase == RDP_P_REF |=> ref_len == $past(cnt))
    else $error("reference not captured");
  chk_bad_interval: assert property (gap_end && phase == RDP_P_DATA && !cls[2]
    |=> push_valid && push_data[3:2] == RDP_K_BAD)
    else $error("bad interval not flagged");
  chk_err_regular: assert property (state == RDP_S_EVAL && ev_err && !ev_wake_err
    |=> o_mode == RDP_M_REGULAR && o_block == `RDP_FIRST_BLOCK && o_cmd_err)
    else $error("error did not give regular read");
  chk_wake_silent: assert property (state == RDP_S_EVAL && ev_wake_err |=> o_mode == RDP_M_SILENT)
    else $error("faulty wake-up still modulates");
  chk_lock_skip: assert property (state == RDP_S_EVAL && !ev_err && !ev_wake_err && ev_write
    && i_lock_map[{opc[0], ev_addr}] |=> state == RDP_S_COLLECT && o_mode == RDP_M_BLOCK)
    else $error("locked block entered programming");
  chk_delay_first: assert property ($rose(o_nvm_erase) |-> $past(state) == RDP_S_DELAY
    && $past(tmr) == 21'h0)
    else $error("erase started without delay");
  chk_step_order: assert property (state == RDP_S_PROGRAM && tmr == 21'h0
    |=> o_nvm_write_chk && !o_nvm_program ##1 state == RDP_S_WRITE_CHK)
    else $error("program not followed by verify");
  chk_verify_fail: assert property (state == RDP_S_WRITE_CHK && tmr == 21'h0 && !i_nvm_ok
    |=> o_mode == RDP_M_SILENT)
    else $error("failed verify still modulates");
  chk_prog_done: assert property (state == RDP_S_WRITE_CHK && tmr == 21'h0 && i_nvm_ok
    |=> o_mode == RDP_M_BLOCK && o_block == $past(o_nvm_addr[2:0]))
    else $error("success did not read written block");
  chk_pwd_reject: assert property (state == RDP_S_EVAL && i_password_mode_bit
    && nbits == `RDP_LEN_PWD_WR && !pwd_ok |=> state != RDP_S_DELAY)
    else $error("wrong password accepted");

  cov_write_done: cover property (state == RDP_S_WRITE_CHK && tmr == 21'h0 && i_nvm_ok);
  cov_lock_skip: cover property (state == RDP_S_EVAL && ev_write && i_lock_map[{opc[0], ev_addr}]);
  cov_pair_sym: cover property (push_valid && push_data[3:2] == RDP_K_PAIR && push_data[1:0] == 2'h3);
  cov_wake_err: cover property (state == RDP_S_EVAL && ev_wake_err);

endmodule : rdp_downlink

`default_nettype wire

/* design/rdp_map.svh */
`ifndef RDP_MAP_SVH
`define RDP_MAP_SVH

// clock and programming timing
`define RDP_CLK_PERIOD_NS 4
`define RDP_PROG_TIME_NS 5600000
`define RDP_PROG_STEPS 4
`define RDP_PROG_DELAY_CYC 32

// interval windows, in field clocks
`define RDP_NRM_LO_OFS 9'h007
`define RDP_FST_LO_OFS 9'h003
`define RDP_NRM_WIN_LOG2 4
`define RDP_FST_WIN_LOG2 3
`define RDP_SYM_BIT 9'h002
`define RDP_SYM_PAIR 9'h004
`define RDP_REF_TMO 8'hFF
`define RDP_CNT_MAX 8'hFF

// command lengths in bits
`define RDP_CMD_MAX 7'h48
`define RDP_LEN_STD_WR 7'h26
`define RDP_LEN_DIRECT 7'h06
`define RDP_LEN_SHORT 7'h02
`define RDP_LEN_SINGLE 7'h00
`define RDP_LEN_PWD_WR 7'h48
`define RDP_LEN_PWD_DIR 7'h28
`define RDP_LEN_WAKE 7'h24
`define RDP_LEN_LIMIT 7'h7F

// opcodes and read start
`define RDP_OP_RESET 2'h0
`define RDP_FIRST_BLOCK 3'h1

`endif

/* design/rdp_pkg.sv */
package rdp_pkg;

  typedef enum logic [6:0] {
    RDP_S_COLLECT = 7'h01,
    RDP_S_EVAL = 7'h02,
    RDP_S_DELAY = 7'h04,
    RDP_S_ERASE = 7'h08,
    RDP_S_ERASE_CHK = 7'h10,
    RDP_S_PROGRAM = 7'h20,
    RDP_S_WRITE_CHK = 7'h40
  } rdp_state_t;

  typedef enum logic [2:0] {
    RDP_P_IDLE = 3'h1,
    RDP_P_REF = 3'h2,
    RDP_P_DATA = 3'h4
  } rdp_phase_t;

  typedef enum logic [1:0] {
    RDP_M_REGULAR = 2'h0,
    RDP_M_BLOCK = 2'h1,
    RDP_M_SILENT = 2'h2,
    RDP_M_PROG = 2'h3
  } rdp_mode_t;

  typedef enum logic [1:0] {
    RDP_K_BIT = 2'h0,
    RDP_K_PAIR = 2'h1,
    RDP_K_BAD = 2'h2,
    RDP_K_END = 2'h3
  } rdp_kind_t;

endpackage : rdp_pkg

/* design/rdp_pair_buf.sv */
`timescale 1ns/1ps
`default_nettype none

module rdp_pair_buf #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= i_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end

endmodule : rdp_pair_buf

`default_nettype wire

/* verif/rdp_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rdp_reader_model (
  output logic o_field_clk,
  output logic o_gap
);

  // carrier runs free, so the field clock never stops
  initial
  begin
    o_field_clk = 1'b0;
    o_gap = 1'b0;
    // keeps carrier edges off the system clock edges
    #0.25;
    forever #62.5 o_field_clk = ~o_field_clk;
  end

  task automatic fc(input int n);
    repeat (n) @(posedge o_field_clk);
  endtask : fc

  // interval spans gap end to gap end, gap itself 8 clocks
  task automatic pulse(input int len);
    fc(len - 8);
    o_gap = 1'b1;
    fc(8);
    o_gap = 1'b0;
  endtask : pulse

  // start gap, reference, symbols; no reference means a lone gap
  task automatic send_frame(input int ref_len, input int iv[$]);
    o_gap = 1'b1;
    fc(15);
    o_gap = 1'b0;
    if (ref_len > 0)
      pulse(ref_len);
    foreach (iv[i])
      pulse(iv[i]);
    fc(ref_len > 0 ? ref_len + 60 : 270);
  endtask : send_frame

endmodule : rdp_reader_model

`default_nettype wire

/* verif/rdp_downlink_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module rdp_downlink_tb;
  import rdp_pkg::*;
  localparam int PROG = 400;
  logic i_clk, i_arst_n, i_field_clk, i_gap, i_one_of_four, i_fast;
  logic i_password_mode_bit, i_answer_on_request, i_nvm_ok;
  logic [31:0] i_password, o_nvm_data;
  logic [15:0] i_lock_map;
  logic [1:0] o_mode, m_mode;
  logic o_page, o_cmd_err, o_nvm_erase, o_nvm_erase_chk, o_nvm_program, o_nvm_write_chk, o_nvm_lock, m_page;
  logic [2:0] o_block, m_block;
  logic [3:0] o_nvm_addr, stb, stb_q;
  logic [36:0] cap;
  int n_mismatch, comparisons, n_err, prog_cyc, dly;
  int seq[$];
  int seed = 32'h56979616;
  bit want_ok = 1'b1;
  bit last_p1;

  rdp_downlink #(.PROG_CYCLES(PROG)) u_rdp_downlink (.i_clk, .i_arst_n, .i_field_clk, .i_gap, .i_one_of_four,
    .i_fast, .i_password_mode_bit, .i_answer_on_request, .i_password, .i_lock_map, .i_nvm_ok, .o_mode, .o_page,
    .o_block, .o_cmd_err, .o_nvm_erase, .o_nvm_erase_chk, .o_nvm_program, .o_nvm_write_chk, .o_nvm_addr,
    .o_nvm_data, .o_nvm_lock);
  rdp_reader_model u_rdp_reader_model (.o_field_clk(i_field_clk), .o_gap(i_gap));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  ////////////////////////////////////////
  // step order, error pulses, programming timing
  assign stb = {o_nvm_write_chk, o_nvm_program, o_nvm_erase_chk, o_nvm_erase};
  always @(posedge i_clk)
  begin
    stb_q <= stb;
    i_nvm_ok <= #1 want_ok | ~o_nvm_write_chk;
    if (o_mode === RDP_M_PROG)
      prog_cyc++;
    if (o_cmd_err === 1'b1)
      n_err++;
    for (int k = 0; k < 4; k++)
      if (stb[k] === 1'b1 && stb_q[k] !== 1'b1)
        seq.push_back(k);
    if (stb[0] === 1'b1 && stb_q[0] !== 1'b1)
    begin
      cap = {o_nvm_lock, o_nvm_addr, o_nvm_data};
      dly = prog_cyc;
    end
  end

  ////////////////////////////////////////
  task automatic check(input logic [36:0] seen, input logic [36:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic setup(input logic [3:0] cfg);
    @(posedge i_clk);
    #1;
    {i_one_of_four, i_fast, i_password_mode_bit, i_answer_on_request} = cfg;
  endtask : setup

  // sends one frame, predicts the outcome, compares
  task automatic run(input logic [71:0] v, input int n, input int bad);
    int refl, st, lo, sym;
    int iv[$];
    logic [1:0] op;
    logic [3:0] adr;
    bit err, prog, wr, dir;
    refl = 15 + $unsigned($random(seed)) % 3;
    st = i_fast ? 8 : 16;
    lo = i_fast ? 2 : 6;
    for (int i = 0; i < n; i += 1 + i_one_of_four)
    begin
      sym = i_one_of_four ? 2 * v[n - 1 - i] + v[n - 2 - i] : v[n - 1 - i];
      iv.push_back(refl + st * sym - lo + $unsigned($random(seed)) % (2 * lo + 2));
    end
    if (bad > 0)
      iv[bad - 1] = refl - 6;
    op = 2'(v >> (n - 2));
    adr = {op[0], v[2:0]};
    wr = bad == 0 && n == (i_password_mode_bit ? 72 : 38) && op[1]
      && (!i_password_mode_bit || v[67:36] === i_password);
    dir = bad == 0 && n == (i_password_mode_bit ? 40 : 6) && op[1]
      && (!i_password_mode_bit || v[35:4] === i_password);
    prog = wr && !i_lock_map[adr];
    err = bad > 0 || (n != 0 && !wr && !dir && !(n == 2 && op != 2'h1));
    if (n == 0 && last_p1)
      {m_mode, m_page, m_block} = {RDP_M_REGULAR, 1'b1, 3'h1};
    else if (wr)
    begin
      {m_mode, m_page, m_block} = {(!prog || want_ok) ? RDP_M_BLOCK : RDP_M_SILENT, op[0], v[2:0]};
      last_p1 = last_p1 | (prog && want_ok && op[0]);
    end
    else if (dir)
      {m_mode, m_page, m_block} = {RDP_M_BLOCK, op[0], v[2:0]};
    else if (n == 36 && i_answer_on_request && i_password_mode_bit)
    begin
      m_mode = RDP_M_SILENT;
      err = 1'b0;
    end
    else if (n != 0)
    begin
      {m_mode, m_page, m_block} = {RDP_M_REGULAR, op[1] & op[0], 3'h1};
      last_p1 = last_p1 && (err || op != 2'h0);
    end
    seq.delete();
    n_err = 0;
    prog_cyc = 0;
    u_rdp_reader_model.send_frame(n == 0 ? 0 : refl, iv);
    check(o_mode, m_mode, "mode");
    check(o_page, m_page, "page");
    check(o_block, m_block, "block");
    check(n_err, err, "error pulse");
    check(seq.size(), prog ? 4 : 0, "step count");
    foreach (seq[k])
      check(seq[k], k, "step order");
    if (prog)
    begin
      check(cap, {v[35], adr, v[34:3]}, "write target");
      check(dly > 30, 1, "start delay");
      check(prog_cyc >= PROG && prog_cyc <= PROG + 40, 1, "programming time");
    end
  endtask : run

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  initial
  begin
    i_arst_n = 1'b0;
    {i_one_of_four, i_fast, i_password_mode_bit, i_answer_on_request} = 4'h0;
    i_nvm_ok = 1'b1;
    i_password = $random(seed);
    i_lock_map = 16'h0010;
    repeat (5) @(posedge i_clk);
    check({o_mode, o_page, o_block, o_cmd_err, stb, o_nvm_addr}, {RDP_M_REGULAR, 4'h1, 9'h0}, "reset");
    #1;
    i_arst_n = 1'b1;
    repeat (2) @(posedge i_clk);
    for (int m = 0; m < 4; m++)
    begin
      setup(4'(m << 2));
      run({70'h0, 1'b1, m[0]}, 2, 0);
    end
    setup(4'hC);
    run({34'h0, 2'b10, 1'b0, 32'($random(seed)), 3'h2}, 38, 0);
    run({34'h0, 2'b10, 1'b1, 32'($random(seed)), 3'h4}, 38, 0);
    want_ok = 1'b0;
    run({34'h0, 2'b10, 1'b0, 32'($random(seed)), 3'h5}, 38, 0);
    want_ok = 1'b1;
    run(72'hF, 4, 2);
    run(72'hA, 4, 0);
    run({66'h0, 2'b11, 1'b0, 3'h6}, 6, 0);
    setup(4'hE);
    run({2'b11, 2'b00, i_password, 1'b0, 32'($random(seed)), 3'h3}, 72, 0);
    run(72'h0, 0, 0);
    setup(4'hF);
    run({36'h0, 2'b10, 2'b00, ~i_password}, 36, 0);
    close_out();
  end

  initial
  begin
    #800000;
    n_mismatch++;
    close_out();
  end

endmodule : rdp_downlink_tb

`default_nettype wire
